// ### shared/pfs_cfg.svh
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// function-select encodings
`define PFS_SEL_GPIO 4'h0
`define PFS_SEL_WIDTH 4

// direction class encodings
`define PFS_DIR_IN 2'h0
`define PFS_DIR_OUT 2'h1
`define PFS_DIR_BIDIR 2'h2
`define PFS_DIR_OD 2'h3

// low-power pad-state encodings
`define PFS_LP_HIZ 2'h0
`define PFS_LP_PULL 2'h1
`define PFS_LP_DRIVE 2'h2

// reset values
`define PFS_RST_SEL 4'h0
`define PFS_RST_LP 2'h0

`endif

// ### shared/pfs_pkg.sv
package pfs_pkg;

    typedef enum logic [1:0] {
        PFS_PWR_ACTIVE = 2'b00,
        PFS_PWR_LOW_POWER_DEEP_SLEEP = 2'b01,
        PFS_PWR_HIB = 2'b10
    } pfs_pwr_t;

    // per-pad low-power programming
    typedef struct packed {
        logic [1:0] state;
        logic level;
    } pfs_lp_cfg_t;

    // per-pad driver controls
    typedef struct packed {
        logic out;
        logic oe;
        logic pull;
    } pfs_pad_drv_t;

endpackage

// ### core/pfs_pad_slice.sv
`timescale 1ns/1ps
`include "pfs_cfg.svh"

module pfs_pad_slice #(
    parameter int NFUNC = 16
) (
    input wire logic [`PFS_SEL_WIDTH-1:0] i_sel,
    input wire logic [NFUNC-1:0] i_fn_out,
    input wire logic [NFUNC-1:0] i_fn_oe,
    input wire logic [2*NFUNC-1:0] i_dir_class,
    input wire logic [NFUNC-1:0] i_fn_valid,
    input wire logic i_gpio_out,
    input wire logic i_gpio_oe,
    output logic [`PFS_SEL_WIDTH-1:0] o_eff_sel,
    output pfs_pkg::pfs_pad_drv_t o_drv
);
    wire logic sel_ok;
    wire logic [1:0] cls;
    wire logic fo;
    wire logic foe;

    // unused encodings fall back to gpio
    assign sel_ok = (i_sel < NFUNC) && i_fn_valid[i_sel];
    assign o_eff_sel = sel_ok ? i_sel : `PFS_SEL_GPIO;
    assign cls = i_dir_class[2*o_eff_sel +: 2];
    assign fo = (o_eff_sel == `PFS_SEL_GPIO) ? i_gpio_out : i_fn_out[o_eff_sel];
    assign foe = (o_eff_sel == `PFS_SEL_GPIO) ? i_gpio_oe : i_fn_oe[o_eff_sel];

    // driver follows the function's direction class
    always_comb begin
        o_drv = '0;
        unique case (cls)
            `PFS_DIR_IN: begin
                o_drv.oe = 1'b0;
                o_drv.out = 1'b0;
            end
            `PFS_DIR_OUT: begin
                o_drv.oe = 1'b1;
                o_drv.out = fo;
            end
            `PFS_DIR_BIDIR: begin
                o_drv.oe = foe;
                o_drv.out = fo;
            end
            `PFS_DIR_OD: begin
                // open drain only ever pulls low
                o_drv.oe = foe & ~fo;
                o_drv.out = 1'b0;
            end
        endcase
    end
endmodule

// ### core/pfs_pad_mux.sv
`timescale 1ns/1ps
`include "pfs_cfg.svh"

// What this block does
// - after reset every pad shows its gpio function, encoding zero
// - in deep sleep, pads unused by active functions float by default
// - in hibernate all pads float by default
// - software may set each pad to pull or drive in low power
// - each function has fixed direction class; driver obeys it

module pfs_pad_mux #(
    parameter int NPADS = 8,
    parameter int NFUNC = 16,
    parameter logic [2*NFUNC-1:0] DIR_CLASS = {
        {13{`PFS_DIR_IN}}, `PFS_DIR_OUT, `PFS_DIR_OD, `PFS_DIR_BIDIR},
    parameter logic [NFUNC-1:0] FN_VALID = 16'h00FF
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_cfg_we,
    input wire logic [$clog2(NPADS)-1:0] i_cfg_pad,
    input wire logic [`PFS_SEL_WIDTH-1:0] i_cfg_sel,
    input wire pfs_pkg::pfs_lp_cfg_t i_cfg_lp,
    input wire logic i_cfg_lp_active,
    input wire pfs_pkg::pfs_pwr_t i_pwr_mode,
    input wire logic [NPADS*NFUNC-1:0] i_fn_out,
    input wire logic [NPADS*NFUNC-1:0] i_fn_oe,
    input wire logic [NPADS-1:0] i_gpio_out,
    input wire logic [NPADS-1:0] i_gpio_oe,
    input wire logic [NPADS-1:0] i_pad_in,
    output logic [NPADS-1:0] o_pad_out,
    output logic [NPADS-1:0] o_pad_oe,
    output logic [NPADS-1:0] o_pad_pull,
    output logic [NPADS*`PFS_SEL_WIDTH-1:0] o_pad_sel,
    output logic [NPADS*NFUNC-1:0] o_fn_in
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_r;
    wire logic rst_n;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ----------------------------------------
    // configuration storage
    // ----------------------------------------
    logic [`PFS_SEL_WIDTH-1:0] sel_r [NPADS];
    pfs_pkg::pfs_lp_cfg_t lp_r [NPADS];
    logic [NPADS-1:0] lp_act_r;

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < NPADS; p++) begin
                sel_r[p] <= `PFS_RST_SEL;
                lp_r[p] <= '{state: `PFS_RST_LP, level: 1'b0};
            end
            lp_act_r <= '0;
        end else if (i_cfg_we) begin
            sel_r[i_cfg_pad] <= i_cfg_sel;
            lp_r[i_cfg_pad] <= i_cfg_lp;
            lp_act_r[i_cfg_pad] <= i_cfg_lp_active;
        end
    end

    // ----------------------------------------
    // per-pad selection and low-power override
    // ----------------------------------------
    pfs_pkg::pfs_pad_drv_t drv_act [NPADS];
    pfs_pkg::pfs_pad_drv_t drv_nxt [NPADS];
    logic [`PFS_SEL_WIDTH-1:0] eff_sel [NPADS];
    wire logic low_power_deep_sleep = (i_pwr_mode == pfs_pkg::PFS_PWR_LOW_POWER_DEEP_SLEEP);
    wire logic hib = (i_pwr_mode == pfs_pkg::PFS_PWR_HIB);

    function automatic pfs_pkg::pfs_pad_drv_t lp_drv(input pfs_pkg::pfs_lp_cfg_t c);
        pfs_pkg::pfs_pad_drv_t d;
        d = '0;
        if (c.state == `PFS_LP_PULL) begin
            d.pull = 1'b1;
            d.out = c.level;
        end else if (c.state == `PFS_LP_DRIVE) begin
            d.oe = 1'b1;
            d.out = c.level;
        end
        return d;
    endfunction

    for (genvar p = 0; p < NPADS; p++) begin : g_pad
        pfs_pad_slice #(
            .NFUNC(NFUNC)
        ) u_slice (
            .i_sel(sel_r[p]),
            .i_fn_out(i_fn_out[p*NFUNC +: NFUNC]),
            .i_fn_oe(i_fn_oe[p*NFUNC +: NFUNC]),
            .i_dir_class(DIR_CLASS),
            .i_fn_valid(FN_VALID),
            .i_gpio_out(i_gpio_out[p]),
            .i_gpio_oe(i_gpio_oe[p]),
            .o_eff_sel(eff_sel[p]),
            .o_drv(drv_act[p])
        );

        // sleep state is a software choice per pad; default floats
        always_comb begin
            drv_nxt[p] = drv_act[p];
            if (hib) begin
                drv_nxt[p] = lp_drv(lp_r[p]);
            end else if (low_power_deep_sleep && !lp_act_r[p]) begin
                drv_nxt[p] = lp_drv(lp_r[p]);
            end
        end
    end

    // ----------------------------------------
    // registered pad outputs
    // ----------------------------------------
    // one cycle latency traded for glitch-free pad drivers
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pad_out <= '0;
            o_pad_oe <= '0;
            o_pad_pull <= '0;
            o_pad_sel <= '0;
            o_fn_in <= '0;
        end else begin
            for (int p = 0; p < NPADS; p++) begin
                o_pad_out[p] <= drv_nxt[p].out;
                o_pad_oe[p] <= drv_nxt[p].oe;
                o_pad_pull[p] <= drv_nxt[p].pull;
                o_pad_sel[p*`PFS_SEL_WIDTH +: `PFS_SEL_WIDTH] <= eff_sel[p];
                for (int f = 0; f < NFUNC; f++) begin
                    // only the selected function sees the pad input
                    o_fn_in[p*NFUNC+f] <= (eff_sel[p] == f[`PFS_SEL_WIDTH-1:0])
                        && i_pad_in[p];
                end
            end
        end
    end
endmodule

// ### verif/pfs_pad_mux_monitor.sv
`timescale 1ns/1ps
module pfs_pad_mux_monitor #(
    parameter int NPADS = 8,
    parameter int NFUNC = 16,
    parameter logic [NFUNC-1:0] FN_VALID = 16'h00FF
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_cfg_we,
    input wire logic [$clog2(NPADS)-1:0] i_cfg_pad,
    input wire logic [3:0] i_cfg_sel,
    input wire pfs_pkg::pfs_pwr_t i_pwr_mode,
    input wire logic [NPADS*NFUNC-1:0] i_fn_out,
    input wire logic [NPADS*NFUNC-1:0] i_fn_oe,
    input wire logic [NPADS-1:0] i_gpio_out,
    input wire logic [NPADS-1:0] i_gpio_oe,
    input wire logic [NPADS-1:0] o_pad_out,
    input wire logic [NPADS-1:0] o_pad_oe,
    input wire logic [NPADS-1:0] o_pad_pull,
    input wire logic [NPADS*4-1:0] o_pad_sel
);
    // ----
    // checks
    // ----
    // skips the reset sync stage, where drivers are forced low
    logic [1:0] up_r;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_active;
        i_pwr_mode == pfs_pkg::PFS_PWR_ACTIVE && $past(i_pwr_mode) == pfs_pkg::PFS_PWR_ACTIVE
            && $past(i_pwr_mode, 2) == pfs_pkg::PFS_PWR_ACTIVE;
    endsequence
    sequence s_hib_quiet;
        (!i_cfg_we && i_pwr_mode == pfs_pkg::PFS_PWR_HIB)[*3]
            ##1 i_pwr_mode == pfs_pkg::PFS_PWR_HIB;
    endsequence
    property p_sel;
        logic [$clog2(NPADS)-1:0] p;
        logic [3:0] s;
        (i_cfg_we, p = i_cfg_pad, s = i_cfg_sel) |->
            ##2 o_pad_sel[p*4 +: 4] == (FN_VALID[s] ? s : 4'h0);
    endproperty
    a_reset_gpio: assert property ($rose(i_rst_n) |-> (o_pad_sel == '0)[*2])
        else $error("selection not gpio after reset");
    a_sel_write: assert property (p_sel)
        else $error("effective selection wrong");
    a_gpio_bidir: assert property (s_active ##0 (up_r == 2'h3 && o_pad_sel[3:0] == 4'h0)
        |-> o_pad_oe[0] == $past(i_gpio_oe[0]) && o_pad_out[0] == $past(i_gpio_out[0]))
        else $error("gpio driver wrong");
    a_od_class: assert property (s_active ##0 (up_r == 2'h3 && o_pad_sel[3:0] == 4'h1)
        |-> !o_pad_out[0] && o_pad_oe[0] == $past(i_fn_oe[1] & ~i_fn_out[1]))
        else $error("open drain driver wrong");
    a_out_class: assert property (s_active ##0 (up_r == 2'h3 && o_pad_sel[3:0] == 4'h2)
        |-> o_pad_oe[0] && o_pad_out[0] == $past(i_fn_out[2]))
        else $error("output driver wrong");
    a_in_class: assert property (s_active ##0 (up_r == 2'h3 && o_pad_sel[3:0] == 4'h3)
        |-> !o_pad_oe[0])
        else $error("input function drives pad");
    a_hib_frozen: assert property (s_hib_quiet |->
        $stable({o_pad_oe, o_pad_out, o_pad_pull}))
        else $error("hibernate pad state moved");
    a_active_nopull: assert property (s_active |-> o_pad_pull == '0)
        else $error("pull on while active");
endmodule
bind pfs_pad_mux pfs_pad_mux_monitor #(.NPADS(NPADS), .NFUNC(NFUNC), .FN_VALID(FN_VALID))
    pfs_pad_mux_monitor_i (.i_core_clk, .i_rst_n, .i_cfg_we, .i_cfg_pad, .i_cfg_sel, .i_pwr_mode,
    .i_fn_out, .i_fn_oe, .i_gpio_out, .i_gpio_oe, .o_pad_out, .o_pad_oe, .o_pad_pull, .o_pad_sel);

// ### verif/test_pad_function_select_lowpower.sv
`timescale 1ns/1ps
module test_pad_function_select_lowpower;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic we = 1'b0;
    logic act = 1'b0;
    logic [2:0] pad = 3'h0;
    logic [3:0] sel = 4'h0;
    pfs_pkg::pfs_lp_cfg_t lp = 3'h0;
    pfs_pkg::pfs_pwr_t mode = pfs_pkg::PFS_PWR_ACTIVE;
    logic [127:0] fn_out = 128'h4;
    logic [127:0] fn_oe = '1;
    logic [7:0] g_out = 8'hFF;
    logic [7:0] g_oe = 8'hFF;
    logic [7:0] pad_in = 8'h01;
    wire logic [7:0] p_out, p_oe, p_pull;
    wire logic [31:0] p_sel;
    wire logic [127:0] fn_in;
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    // ----
    // stimulus
    // ----
    pfs_pad_mux pfs_pad_mux_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_cfg_we(we), .i_cfg_pad(pad),
        .i_cfg_sel(sel), .i_cfg_lp(lp), .i_cfg_lp_active(act), .i_pwr_mode(mode),
        .i_fn_out(fn_out), .i_fn_oe(fn_oe), .i_gpio_out(g_out), .i_gpio_oe(g_oe),
        .i_pad_in(pad_in), .o_pad_out(p_out), .o_pad_oe(p_oe), .o_pad_pull(p_pull),
        .o_pad_sel(p_sel), .o_fn_in(fn_in));
    task automatic print_verdict;
        if (fails == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] p, input logic [3:0] s, input logic [2:0] l,
        input logic a);
        @(negedge clk);
        {we, pad, sel, lp, act} = {1'b1, p, s, l, a};
        @(negedge clk);
        we = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic t_classes;
        logic [3:0] s [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};
        logic [5:0] e [5] = '{6'h03, 6'h06, 6'h0B, 6'h0C, 6'h03};
        for (int i = 0; i < 5; i++) begin
            wr(3'h0, s[i], 3'h0, 1'b0);
            chk({10'h000, p_sel[3:0], p_oe[0], p_out[0]}, {10'h000, e[i]});
            chk(fn_in[15:0], 16'h0001 << e[i][5:2]);
        end
    endtask
    task automatic t_lowpower;
        wr(3'h1, 4'h0, 3'h3, 1'b0);
        wr(3'h2, 4'h0, 3'h4, 1'b0);
        wr(3'h3, 4'h0, 3'h5, 1'b0);
        mode = pfs_pkg::PFS_PWR_HIB;
        repeat (5) @(negedge clk);
        chk({p_out, p_oe}, 16'h0A0C);
        chk({8'h00, p_pull}, 16'h0002);
        wr(3'h0, 4'h0, 3'h0, 1'b1);
        mode = pfs_pkg::PFS_PWR_LOW_POWER_DEEP_SLEEP;
        repeat (4) @(negedge clk);
        chk({p_out, p_oe}, 16'h0B0D);
        mode = pfs_pkg::PFS_PWR_ACTIVE;
        repeat (4) @(negedge clk);
        chk({p_pull, p_oe}, 16'h00FF);
    endtask
    initial begin
        forever #2 clk = ~clk;
    end
    // bounded run: the whole sequence needs well under 300 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            fails++;
            print_verdict;
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        chk({p_sel[15:0]}, 16'h0000);
        chk({8'h00, p_oe}, 16'h00FF);
        t_classes;
        t_lowpower;
        print_verdict;
    end
endmodule
